/* dsjs_regs.svh */
`ifndef DSJS_REGS_SVH
`define DSJS_REGS_SVH

// Internal control word bit positions
`define DSJS_CW_ON_NORMAL 0
`define DSJS_CW_COAST_OK 1
`define DSJS_CW_QUICK_OK 2
`define DSJS_CW_OP_ENABLE 3
`define DSJS_CW_JOG_ONE 8
`define DSJS_CW_JOG_TWO 9

// Internal status word bit positions
`define DSJS_SW_READY_TO_START 0
`define DSJS_SW_READY 1
`define DSJS_SW_OP_ENABLED 2
`define DSJS_SW_ON_INHIBITED 6
`define DSJS_SW_PULSES 11

// Second telegram status word
`define DSJS_TSW2_PULSES 10

// Jog-active bit of the drive state word
`define DSJS_DSW_JOG_ACTIVE 31

// Telegram types with automatic jog mapping
`define DSJS_TG_JOG_A 8'h07
`define DSJS_TG_JOG_B 8'h09
`define DSJS_TG_JOG_C 8'h6e
`define DSJS_TG_JOG_D 8'h6f

// Interface mode that shows pulses in the second status word
`define DSJS_IF_MODE_PULSES 4'h0

// Fixed setpoint selection
`define DSJS_FIX_COUNT 15
`define DSJS_FIX_NONE 4'h0

// Word widths and reset values
`define DSJS_WORD_W 16
`define DSJS_WORD_RESET 16'h0000
`define DSJS_PIN_W 8
`define DSJS_PIN_RESET 8'h00

`endif

/* dsjs_pkg.sv */
package dsjs_pkg;

  typedef enum logic [7:0] {
    DSJS_INHIBITED = 8'h01,
    DSJS_READY_TO_START = 8'h02,
    DSJS_READY = 8'h04,
    DSJS_OPERATION = 8'h08,
    DSJS_STOPPING = 8'h10,
    DSJS_QUICK_STOP = 8'h20,
    DSJS_JOG = 8'h40,
    DSJS_JOG_STOP = 8'h80
  } dsjs_state_type;

endpackage

/* dsjs_fixed_select.sv */
`timescale 1ns/1ps
`include "dsjs_regs.svh"

module dsjs_fixed_select #(
  parameter int SPEED_W = 16
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [3:0] wr_index,
  input wire logic [SPEED_W-1:0] wr_data,
  input wire logic [3:0] sel,
  output logic [`DSJS_FIX_COUNT*SPEED_W-1:0] fixed_setpoints,
  output logic [SPEED_W-1:0] fixed_setpoint_effective,
  output logic [3:0] selected_fixed_setpoint_number
);

  logic [SPEED_W-1:0] store [1:`DSJS_FIX_COUNT];

  // Stored setpoints, index zero is not a slot
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 1; i <= `DSJS_FIX_COUNT; i++) begin
        store[i] <= '0;
      end
    end else if (wr_en && wr_index != `DSJS_FIX_NONE) begin
      store[wr_index] <= wr_data;
    end
  end

  always_comb begin
    for (int i = 1; i <= `DSJS_FIX_COUNT; i++) begin
      fixed_setpoints[(i-1)*SPEED_W +: SPEED_W] = store[i];
    end
  end

  // Selection by binary value, zero selects a zero setpoint
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      fixed_setpoint_effective <= '0;
      selected_fixed_setpoint_number <= `DSJS_FIX_NONE;
    end else begin
      selected_fixed_setpoint_number <= sel;
      if (sel == `DSJS_FIX_NONE) begin
        fixed_setpoint_effective <= '0;
      end else begin
        fixed_setpoint_effective <= store[sel];
      end
    end
  end

endmodule

/* dsjs_top.sv */
`timescale 1ns/1ps
`include "dsjs_regs.svh"

module dsjs_top #(
  parameter int SPEED_W = 16,
  parameter int SCALE_FRAC = 14
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic fixed_wr_en,
  input wire logic [3:0] fixed_wr_index,
  input wire logic [SPEED_W-1:0] fixed_wr_data,
  input wire logic [3:0] fixed_sel_pin,
  input wire logic [3:0] fixed_sel_connected,
  output logic [`DSJS_FIX_COUNT*SPEED_W-1:0] fixed_setpoints,
  output logic [SPEED_W-1:0] fixed_setpoint_effective,
  output logic [3:0] selected_fixed_setpoint_number,
  input wire logic [SPEED_W-1:0] main_setpoint,
  input wire logic [SPEED_W-1:0] main_scale,
  input wire logic [SPEED_W-1:0] supp_setpoint,
  input wire logic [SPEED_W-1:0] supp_scale,
  output logic [SPEED_W-1:0] main_setpoint_effective,
  output logic [SPEED_W-1:0] supp_setpoint_effective,
  output logic [SPEED_W-1:0] total_setpoint_effective,
  input wire logic [15:0] telegram_control_word_one,
  input wire logic [7:0] telegram_type,
  input wire logic jog_one_request,
  input wire logic jog_two_request,
  input wire logic coast_stop_cmd_n,
  input wire logic quick_stop_cmd_n,
  input wire logic [SPEED_W-1:0] jog_one_speed,
  input wire logic [SPEED_W-1:0] jog_two_speed,
  input wire logic [SPEED_W-2:0] maximum_speed_reference,
  input wire logic [SPEED_W-2:0] minimum_speed_limit,
  input wire logic [SPEED_W-2:0] skip_band_low,
  input wire logic [SPEED_W-2:0] skip_band_high,
  input wire logic [SPEED_W-2:0] ramp_up_step,
  input wire logic [SPEED_W-2:0] ramp_down_step,
  input wire logic [SPEED_W-2:0] quick_down_step,
  input wire logic ramp_freeze_request,
  input wire logic [SPEED_W-1:0] speed_ctrl_setpoint_in_one,
  input wire logic [SPEED_W-1:0] speed_ctrl_setpoint_in_two,
  input wire logic [3:0] interface_mode_setting,
  output logic [SPEED_W-1:0] ramp_speed,
  output logic [SPEED_W-1:0] speed_setpoint_out,
  output logic [15:0] internal_control_word,
  output logic [15:0] internal_status_word,
  output logic [15:0] telegram_status_word_one,
  output logic [15:0] telegram_status_word_two,
  output logic jog_active_flag,
  output dsjs_pkg::dsjs_state_type drive_state
);
  import dsjs_pkg::*;

  localparam logic signed [SPEED_W-1:0] SMAX = {1'b0, {(SPEED_W-1){1'b1}}};
  localparam logic signed [SPEED_W-1:0] SMIN = {1'b1, {(SPEED_W-1){1'b0}}};

  if (SPEED_W < 8 || SCALE_FRAC < 1 || SCALE_FRAC >= SPEED_W) begin : g_bad
    $error("dsjs_top: unsupported SPEED_W or SCALE_FRAC");
  end

  function automatic logic signed [SPEED_W-1:0] sat_add(
    input logic signed [SPEED_W-1:0] a,
    input logic signed [SPEED_W-1:0] b
  );
    logic signed [SPEED_W:0] s;
    s = {a[SPEED_W-1], a} + {b[SPEED_W-1], b};
    if (s[SPEED_W] != s[SPEED_W-1]) begin
      return s[SPEED_W] ? SMIN : SMAX;
    end
    return s[SPEED_W-1:0];
  endfunction

  function automatic logic signed [SPEED_W-1:0] scale(
    input logic signed [SPEED_W-1:0] v,
    input logic signed [SPEED_W-1:0] k
  );
    logic signed [2*SPEED_W-1:0] p;
    logic signed [2*SPEED_W-1:0] q;
    p = v * k;
    q = p >>> SCALE_FRAC;
    if (q > SMAX) begin
      return SMAX;
    end
    if (q < SMIN) begin
      return SMIN;
    end
    return q[SPEED_W-1:0];
  endfunction

  // Maximum clamp, skip band, then minimum speed on the magnitude
  function automatic logic signed [SPEED_W-1:0] limit_target(
    input logic signed [SPEED_W-1:0] t
  );
    logic neg;
    logic [SPEED_W-1:0] m;
    neg = t[SPEED_W-1];
    m = neg ? -t : t;
    if (m > {1'b0, maximum_speed_reference}) begin
      m = {1'b0, maximum_speed_reference};
    end
    if (m > {1'b0, skip_band_low} && m < {1'b0, skip_band_high}) begin
      m = {1'b0, skip_band_low};
    end
    if (m < {1'b0, minimum_speed_limit}) begin
      m = {1'b0, minimum_speed_limit};
    end
    return neg ? $signed(-m) : $signed(m);
  endfunction

  // One ramp step; growing magnitude uses the up step, except from zero toward a negative target, which uses the down step
  function automatic logic signed [SPEED_W-1:0] ramp_step(
    input logic signed [SPEED_W-1:0] cur,
    input logic signed [SPEED_W-1:0] tgt,
    input logic [SPEED_W-2:0] up,
    input logic [SPEED_W-2:0] dn
  );
    logic signed [SPEED_W:0] c;
    logic signed [SPEED_W:0] t;
    logic signed [SPEED_W:0] s;
    logic [SPEED_W-2:0] st;
    c = {cur[SPEED_W-1], cur};
    t = {tgt[SPEED_W-1], tgt};
    st = (cur[SPEED_W-1] ? (t < c) : (t > c)) ? up : dn;
    if (t > c) begin
      s = c + $signed({2'h0, st});
      if (s > t) begin
        s = t;
      end
    end else begin
      s = c - $signed({2'h0, st});
      if (s < t) begin
        s = t;
      end
    end
    return s[SPEED_W-1:0];
  endfunction

  function automatic logic [15:0] status_of(input dsjs_state_type s);
    logic [15:0] w;
    logic pulses;
    w = `DSJS_WORD_RESET;
    pulses = s inside {DSJS_OPERATION, DSJS_STOPPING, DSJS_QUICK_STOP,
                       DSJS_JOG, DSJS_JOG_STOP};
    w[`DSJS_SW_READY_TO_START] = s != DSJS_INHIBITED;
    w[`DSJS_SW_READY] = pulses || s == DSJS_READY;
    w[`DSJS_SW_OP_ENABLED] = pulses && s != DSJS_QUICK_STOP;
    w[`DSJS_SW_ON_INHIBITED] = s == DSJS_INHIBITED;
    w[`DSJS_SW_PULSES] = pulses;
    return w;
  endfunction

  // Pin synchroniser: select bits, jog pins, stop pins
  logic [`DSJS_PIN_W-1:0] pin_s1;
  logic [`DSJS_PIN_W-1:0] pin_s2;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1 <= `DSJS_PIN_RESET;
      pin_s2 <= `DSJS_PIN_RESET;
    end else begin
      pin_s1 <= {~quick_stop_cmd_n, ~coast_stop_cmd_n, jog_two_request,
                 jog_one_request, fixed_sel_pin};
      pin_s2 <= pin_s1;
    end
  end

  logic [3:0] sel_eff;
  assign sel_eff = pin_s2[3:0] & fixed_sel_connected;

  dsjs_fixed_select #(
    .SPEED_W(SPEED_W)
  ) u_fixed (
    .clock(clock),
    .rst_n(rst_n),
    .wr_en(fixed_wr_en),
    .wr_index(fixed_wr_index),
    .wr_data(fixed_wr_data),
    .sel(sel_eff),
    .fixed_setpoints(fixed_setpoints),
    .fixed_setpoint_effective(fixed_setpoint_effective),
    .selected_fixed_setpoint_number(selected_fixed_setpoint_number)
  );

  // Main plus supplementary with individual scaling
  logic signed [SPEED_W-1:0] next_main;
  logic signed [SPEED_W-1:0] next_supp;
  assign next_main = scale(main_setpoint, main_scale);
  assign next_supp = scale(supp_setpoint, supp_scale);
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      main_setpoint_effective <= '0;
      supp_setpoint_effective <= '0;
      total_setpoint_effective <= '0;
    end else begin
      main_setpoint_effective <= next_main;
      supp_setpoint_effective <= next_supp;
      total_setpoint_effective <= sat_add(next_main, next_supp);
    end
  end

  // Command sources
  logic tg_auto;
  logic jog_one;
  logic jog_two;
  logic jog_any;
  logic on_cmd;
  logic op_en;
  logic coast_ok;
  logic quick_ok;
  assign tg_auto = telegram_type inside {`DSJS_TG_JOG_A, `DSJS_TG_JOG_B,
                                         `DSJS_TG_JOG_C, `DSJS_TG_JOG_D};
  assign jog_one = tg_auto ? telegram_control_word_one[`DSJS_CW_JOG_ONE]
                           : pin_s2[4];
  assign jog_two = tg_auto ? telegram_control_word_one[`DSJS_CW_JOG_TWO]
                           : pin_s2[5];
  assign jog_any = jog_one || jog_two;
  assign on_cmd = telegram_control_word_one[`DSJS_CW_ON_NORMAL];
  assign op_en = telegram_control_word_one[`DSJS_CW_OP_ENABLE];
  assign coast_ok = telegram_control_word_one[`DSJS_CW_COAST_OK]
                    && !pin_s2[6];
  assign quick_ok = telegram_control_word_one[`DSJS_CW_QUICK_OK]
                    && !pin_s2[7];

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      internal_control_word <= `DSJS_WORD_RESET;
    end else begin
      internal_control_word <= `DSJS_WORD_RESET;
      internal_control_word[`DSJS_CW_ON_NORMAL] <= on_cmd;
      internal_control_word[`DSJS_CW_COAST_OK] <= coast_ok;
      internal_control_word[`DSJS_CW_QUICK_OK] <= quick_ok;
      internal_control_word[`DSJS_CW_OP_ENABLE] <= op_en;
      internal_control_word[`DSJS_CW_JOG_ONE] <= jog_one;
      internal_control_word[`DSJS_CW_JOG_TWO] <= jog_two;
    end
  end

  // Sequence control
  dsjs_state_type state;
  dsjs_state_type next_state;
  logic ramp_zero;
  assign ramp_zero = ramp_speed == '0;

  always_comb begin
    next_state = state;
    if (!coast_ok) begin
      next_state = DSJS_INHIBITED;
    end else begin
      case (state)
        DSJS_INHIBITED: begin
          if (quick_ok && !on_cmd) begin
            next_state = DSJS_READY_TO_START;
          end
        end
        DSJS_READY_TO_START: begin
          if (!quick_ok) begin
            next_state = DSJS_INHIBITED;
          end else if (on_cmd) begin
            next_state = DSJS_READY;
          end else if (jog_any) begin
            next_state = DSJS_JOG;
          end
        end
        DSJS_READY: begin
          if (!quick_ok) begin
            next_state = DSJS_INHIBITED;
          end else if (!on_cmd) begin
            next_state = DSJS_READY_TO_START;
          end else if (op_en) begin
            next_state = DSJS_OPERATION;
          end
        end
        DSJS_OPERATION: begin
          if (!quick_ok) begin
            next_state = DSJS_QUICK_STOP;
          end else if (!on_cmd) begin
            next_state = DSJS_STOPPING;
          end else if (!op_en) begin
            next_state = DSJS_READY;
          end
        end
        DSJS_STOPPING: begin
          if (!quick_ok) begin
            next_state = DSJS_QUICK_STOP;
          end else if (on_cmd && op_en) begin
            next_state = DSJS_OPERATION;
          end else if (ramp_zero) begin
            next_state = DSJS_READY_TO_START;
          end
        end
        DSJS_QUICK_STOP: begin
          if (ramp_zero) begin
            next_state = DSJS_INHIBITED;
          end
        end
        DSJS_JOG: begin
          if (!quick_ok) begin
            next_state = DSJS_QUICK_STOP;
          end else if (on_cmd) begin
            next_state = DSJS_READY;
          end else if (!jog_any) begin
            next_state = DSJS_JOG_STOP;
          end
        end
        DSJS_JOG_STOP: begin
          if (!quick_ok) begin
            next_state = DSJS_QUICK_STOP;
          end else if (on_cmd) begin
            next_state = DSJS_READY;
          end else if (jog_any) begin
            next_state = DSJS_JOG;
          end else if (ramp_zero) begin
            next_state = DSJS_READY_TO_START;
          end
        end
        default: begin
          next_state = DSJS_INHIBITED;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= DSJS_INHIBITED;
    end else begin
      state <= next_state;
    end
  end
  assign drive_state = state;

  // Ramp generator
  logic jog_mode;
  logic pulses;
  logic ramp_hold;
  logic signed [SPEED_W-1:0] jog_target;
  logic signed [SPEED_W-1:0] ramp_target;
  logic [SPEED_W-2:0] down_sel;
  assign jog_mode = state == DSJS_JOG || state == DSJS_JOG_STOP;
  logic [15:0] state_status;
  assign state_status = status_of(state);
  assign pulses = state_status[`DSJS_SW_PULSES];
  assign jog_target = jog_one ? jog_one_speed : jog_two_speed;
  assign ramp_hold = (ramp_freeze_request && !jog_mode)
                     || (state == DSJS_JOG && jog_one && jog_two);
  assign down_sel = state == DSJS_QUICK_STOP ? quick_down_step
                                             : ramp_down_step;

  always_comb begin
    case (state)
      DSJS_OPERATION: ramp_target = limit_target(total_setpoint_effective);
      DSJS_JOG: begin
        ramp_target = jog_any ? limit_target(jog_target) : '0;
      end
      default: ramp_target = '0;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ramp_speed <= '0;
    end else if (!pulses || !coast_ok) begin
      ramp_speed <= '0;
    end else if (!ramp_hold) begin
      ramp_speed <= ramp_step(ramp_speed, ramp_target, ramp_up_step,
                              down_sel);
    end
  end

  // Speed controller setpoint
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      speed_setpoint_out <= '0;
    end else if (jog_mode) begin
      speed_setpoint_out <= sat_add(ramp_speed,
                                    speed_ctrl_setpoint_in_two);
    end else begin
      speed_setpoint_out <= sat_add(sat_add(ramp_speed,
                                    speed_ctrl_setpoint_in_one),
                                    speed_ctrl_setpoint_in_two);
    end
  end

  // Status words
  logic [15:0] next_status;
  assign next_status = status_of(next_state);
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      internal_status_word <= status_of(DSJS_INHIBITED);
      telegram_status_word_one <= `DSJS_WORD_RESET;
      telegram_status_word_two <= `DSJS_WORD_RESET;
      jog_active_flag <= 1'b0;
    end else begin
      internal_status_word <= next_status;
      telegram_status_word_one <= next_status & ~(16'h0001 << `DSJS_SW_PULSES);
      telegram_status_word_two <= `DSJS_WORD_RESET;
      telegram_status_word_two[`DSJS_TSW2_PULSES] <=
        next_status[`DSJS_SW_PULSES] &&
        interface_mode_setting == `DSJS_IF_MODE_PULSES;
      jog_active_flag <= next_state == DSJS_JOG
                         || next_state == DSJS_JOG_STOP;
    end
  end

  // Checks
  sequence s_jog_steady;
    state == DSJS_JOG && coast_ok && quick_ok && !on_cmd;
  endsequence

  sequence s_jog_start;
    state == DSJS_READY_TO_START && coast_ok && quick_ok && !on_cmd
      && jog_any;
  endsequence

  a_zero_select: assert property (
    @(posedge clock) disable iff (!rst_n)
    sel_eff == `DSJS_FIX_NONE |=> fixed_setpoint_effective == '0)
    else $error("fixed setpoint not zero for selection zero");

  a_unused_select: assert property (
    @(posedge clock) disable iff (!rst_n)
    1'b1 |=> (selected_fixed_setpoint_number
      & ~$past(fixed_sel_connected)) == 4'h0)
    else $error("unconnected select bit seen high");

  a_total_sum: assert property (
    @(posedge clock) disable iff (!rst_n)
    total_setpoint_effective ==
      sat_add(main_setpoint_effective, supp_setpoint_effective))
    else $error("total setpoint is not main plus supplementary");

  a_jog_switch_on: assert property (
    @(posedge clock) disable iff (!rst_n)
    s_jog_start |=> state == DSJS_JOG ##0 jog_active_flag)
    else $error("jog did not switch on from ready to start");

  a_on_beats_jog: assert property (
    @(posedge clock) disable iff (!rst_n)
    state == DSJS_JOG && coast_ok && quick_ok && on_cmd
      |=> state == DSJS_READY)
    else $error("on command did not take precedence over jog");

  a_stop_beats_jog: assert property (
    @(posedge clock) disable iff (!rst_n)
    jog_mode && !coast_ok |=> state == DSJS_INHIBITED
      ##0 ramp_speed == '0)
    else $error("coast stop did not override jog");

  a_quick_over_jog: assert property (
    @(posedge clock) disable iff (!rst_n)
    jog_mode && coast_ok && !quick_ok |=> state == DSJS_QUICK_STOP)
    else $error("quick stop did not override jog");

  a_both_jog_hold: assert property (
    @(posedge clock) disable iff (!rst_n)
    s_jog_steady ##0 jog_one && jog_two |=> $stable(ramp_speed))
    else $error("speed not held with both jog requests");

  a_jog_blocks_one: assert property (
    @(posedge clock) disable iff (!rst_n)
    jog_mode |=> speed_setpoint_out == sat_add($past(ramp_speed),
      $past(speed_ctrl_setpoint_in_two)))
    else $error("jog setpoint not ramp plus input two");

  a_freeze_in_jog: assert property (
    @(posedge clock) disable iff (!rst_n)
    s_jog_steady ##0 ramp_freeze_request && jog_one && !jog_two
      && ramp_speed != ramp_target && ramp_up_step != '0
      && ramp_down_step != '0 |=> !$stable(ramp_speed))
    else $error("ramp froze during jog");

  a_pulse_report: assert property (
    @(posedge clock) disable iff (!rst_n)
    internal_status_word[`DSJS_SW_PULSES] |-> pulses
      && (telegram_status_word_two[`DSJS_TSW2_PULSES]
          == ($past(interface_mode_setting) == `DSJS_IF_MODE_PULSES)))
    else $error("pulse status bits inconsistent");

endmodule

/* dsjs_ctrl_model.sv */
`timescale 1ns/1ps
module dsjs_ctrl_model (
  input wire logic on_req,
  input wire logic force_on,
  input wire logic [1:0] jog_req,
  output logic [15:0] tcw
);
  // Stops released, enable follows on
  always_comb begin
    tcw = 16'h0006;
    tcw[0] = force_on | (on_req & ~|jog_req);
    tcw[3] = on_req;
    tcw[9:8] = jog_req;
  end
endmodule

/* dsjs_top_test.sv */
`timescale 1ns/1ps
module dsjs_top_test;
  import dsjs_pkg::*;
  typedef struct {int k; logic [15:0] e;} dsjs_note_type;
  logic clock, rst_n, fixed_wr_en, jog_one_request, jog_two_request;
  logic coast_stop_cmd_n, quick_stop_cmd_n, ramp_freeze_request;
  logic jog_active_flag, on_req, force_on;
  logic [1:0] jog_req;
  logic [3:0] fixed_wr_index, fixed_sel_pin, fixed_sel_connected;
  logic [3:0] selected_fixed_setpoint_number, interface_mode_setting;
  logic [7:0] telegram_type;
  logic [239:0] fixed_setpoints;
  logic [15:0] fixed_wr_data, fixed_setpoint_effective, main_setpoint;
  logic [15:0] main_scale, supp_setpoint, supp_scale, main_setpoint_effective;
  logic [15:0] supp_setpoint_effective, total_setpoint_effective;
  logic [15:0] telegram_control_word_one, jog_one_speed, jog_two_speed;
  logic [15:0] speed_ctrl_setpoint_in_one, speed_ctrl_setpoint_in_two;
  logic [15:0] ramp_speed, speed_setpoint_out, internal_control_word;
  logic [15:0] internal_status_word, telegram_status_word_one;
  logic [15:0] telegram_status_word_two;
  logic [14:0] maximum_speed_reference, minimum_speed_limit, skip_band_low;
  logic [14:0] skip_band_high, ramp_up_step, ramp_down_step, quick_down_step;
  dsjs_state_type drive_state;
  dsjs_note_type notes[$];
  dsjs_note_type n;
  logic [15:0] slot[16];
  logic [3:0] s, c;
  logic [15:0] m, p;
  int mismatches = 0;
  int compares = 0;
  int seed = 90704;
  event chk;

  dsjs_top dut_u (.*);
  dsjs_ctrl_model ctrl_u (.on_req(on_req), .force_on(force_on),
    .jog_req(jog_req), .tcw(telegram_control_word_one));

  initial begin
    clock = 0;
    forever #50 clock = ~clock;
  end

  task stop_test;
    if (mismatches == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task cmp_word(input logic [15:0] a, input logic [15:0] e);
    compares++;
    if (a !== e) begin
      mismatches++;
      $display("[ERR] %0t act=%h exp=%h", $time, a, e);
    end
  endtask

  task note(input int k, input logic [15:0] e);
    notes.push_back('{k, e});
  endtask

  task cyc(input int k);
    repeat (k) @(negedge clock);
  endtask

  function automatic logic [15:0] pick(input int k);
    case (k)
      0: return internal_status_word;
      1: return {8'h00, drive_state};
      2: return {15'h0000, jog_active_flag};
      3: return fixed_setpoint_effective;
      4: return {12'h000, selected_fixed_setpoint_number};
      5: return main_setpoint_effective;
      6: return supp_setpoint_effective;
      7: return total_setpoint_effective;
      8: return ramp_speed;
      9: return speed_setpoint_out;
      10: return {5'h00, telegram_status_word_two[10], 10'h000};
      11: return internal_control_word;
      12: return telegram_status_word_one;
      default: return fixed_setpoints[(k-16)*16 +: 16];
    endcase
  endfunction

  initial begin
    forever begin
      @chk;
      while (notes.size() > 0) begin
        n = notes.pop_front();
        cmp_word(pick(n.k), n.e);
      end
    end
  end

  initial begin
    #(2000 * 100);
    mismatches++;
    stop_test;
  end

  initial begin
    {rst_n, fixed_wr_en, jog_one_request, jog_two_request} = 4'h0;
    {ramp_freeze_request, on_req, force_on, jog_req} = 5'h00;
    {coast_stop_cmd_n, quick_stop_cmd_n} = 2'b11;
    {fixed_wr_index, fixed_sel_pin, interface_mode_setting} = 12'h000;
    fixed_sel_connected = 4'hf;
    telegram_type = 8'h07;
    {fixed_wr_data, main_setpoint, supp_setpoint} = 48'h0;
    main_scale = 16'h4000;
    supp_scale = 16'h2000;
    jog_one_speed = 16'h0100;
    jog_two_speed = 16'h0300;
    speed_ctrl_setpoint_in_one = 16'h0200;
    speed_ctrl_setpoint_in_two = 16'h0010;
    maximum_speed_reference = 15'h7fff;
    {minimum_speed_limit, skip_band_low, skip_band_high} = 45'h0;
    {ramp_up_step, ramp_down_step, quick_down_step} = {3{15'h0040}};
    quick_down_step = 15'h0080;
    slot[0] = 16'h0000;
    cyc(4);
    rst_n = 1;
    note(0, 16'h0040);
    note(1, 16'h0001);
    ->chk;
    for (int i = 1; i < 16; i++) begin
      fixed_wr_en = 1;
      fixed_wr_index = i[3:0];
      fixed_wr_data = 16'($random(seed));
      slot[i] = fixed_wr_data;
      cyc(1);
    end
    fixed_wr_en = 0;
    for (int j = 0; j < 10; j++) begin
      s = (j == 0) ? 4'h0 : 4'($random(seed));
      c = 4'($random(seed));
      fixed_sel_pin = s;
      fixed_sel_connected = c;
      cyc(6);
      note(4, {12'h000, s & c});
      note(3, slot[s & c]);
      note(16 + j, slot[j + 1]);
      ->chk;
    end
    for (int j = 0; j < 4; j++) begin
      m = 16'($random(seed)) & 16'h0fff;
      p = 16'($random(seed)) & 16'h0fff;
      main_setpoint = m;
      supp_setpoint = p;
      cyc(3);
      note(5, m);
      note(6, p >> 1);
      note(7, m + (p >> 1));
      ->chk;
    end
    main_setpoint = 16'h7fff;
    main_scale = 16'h7fff;
    ramp_freeze_request = 1;
    cyc(3);
    note(5, 16'h7fff);
    note(7, 16'h7fff);
    note(1, 16'h0002);
    note(0, 16'h0001);
    ->chk;
    jog_req = 2'b01;
    cyc(12);
    note(1, 16'h0040);
    note(2, 16'h0001);
    note(0, 16'h0807);
    note(8, 16'h0100);
    note(9, 16'h0110);
    note(10, 16'h0400);
    ->chk;
    interface_mode_setting = 4'h3;
    jog_req = 2'b11;
    cyc(8);
    note(10, 16'h0000);
    note(8, 16'h0100);
    ->chk;
    jog_req = 2'b00;
    cyc(12);
    note(1, 16'h0002);
    note(2, 16'h0000);
    note(8, 16'h0000);
    ->chk;
    force_on = 1;
    jog_req = 2'b01;
    cyc(4);
    note(1, 16'h0004);
    ->chk;
    force_on = 0;
    jog_req = 2'b00;
    cyc(8);
    jog_req = 2'b01;
    cyc(8);
    force_on = 1;
    cyc(2);
    note(1, 16'h0004);
    ->chk;
    force_on = 0;
    cyc(8);
    coast_stop_cmd_n = 0;
    cyc(5);
    note(1, 16'h0001);
    note(8, 16'h0000);
    ->chk;
    coast_stop_cmd_n = 1;
    telegram_type = 8'h01;
    jog_two_request = 1;
    cyc(18);
    note(1, 16'h0040);
    note(8, 16'h0300);
    note(11, 16'h0206);
    note(12, 16'h0007);
    ->chk;
    quick_stop_cmd_n = 0;
    ramp_freeze_request = 0;
    cyc(4);
    note(1, 16'h0020);
    note(8, 16'h0280);
    ->chk;
    cyc(8);
    note(1, 16'h0001);
    note(8, 16'h0000);
    note(2, 16'h0000);
    ->chk;
    cyc(1);
    stop_test;
  end
endmodule
